// [verilog/bfifo_defines.svh]
// constants for the bidirectional fifo port control
// assumes inclusion by bare name from package and design files
`ifndef BFIFO_DEFINES_SVH
`define BFIFO_DEFINES_SVH
// =========================================
// widths and depth
`define BF_DATA_W 36
`define BF_DEPTH 64
// full flag rises on this edge after reset
`define BF_RDY_EDGES 2'h2
// almost flag offsets by offset select
`define BF_OFF_11 5'h10
`define BF_OFF_10 5'h0c
`define BF_OFF_01 5'h08
`define BF_OFF_00 5'h04
// swap select codes (hi:lo)
`define BF_SW_NONE 2'h0
`define BF_SW_BYTE 2'h1
`define BF_SW_WORD 2'h2
`define BF_SW_BW 2'h3
`endif

// [verilog/bfifo_pkg.sv]
// types shared by the port control design
// assumes bfifo_defines.svh on the include path
`include "bfifo_defines.svh"
`default_nettype none
package bfifo_pkg;
  typedef logic [`BF_DATA_W-1:0] data_type;
  // port a control pins
  typedef struct packed {
    logic porta_chip_sel_n;
    logic porta_wr_rd_sel;
    logic porta_enable;
    logic porta_mailbox_sel;
    logic porta_parity_gen;
  } porta_ctl_type;
  // port b control pins
  typedef struct packed {
    logic       portb_chip_sel_n;
    logic       portb_wr_rd_sel;
    logic       portb_enable;
    logic [1:0] portb_size;       // hi:lo
    logic       endian_sel;
    logic [1:0] swap_sel;         // hi:lo
    logic       portb_parity_gen;
  } portb_ctl_type;
  // status flags, all active low
  typedef struct packed {
    logic porta_full_n;
    logic porta_empty_n;
    logic porta_almost_empty_n;
    logic porta_almost_full_n;
    logic portb_full_n;
    logic portb_empty_n;
    logic portb_almost_empty_n;
    logic portb_almost_full_n;
    logic a2b_mail_flag_n;
    logic b2a_mail_flag_n;
  } flags_type;
endpackage
`default_nettype wire

// [verilog/bidir_fifo_port_control.sv]
// bidirectional fifo port control with two fifos and two mailboxes
// assumes both ports share i_ref_clk; pins sampled synchronously
//
// Summary of operation
// R1: with port-b parity generate high, parity is generated on port-b reads
// R2: each generated parity bit sits in the top bit of its byte
// R3: odd/even select input sets generated parity kind
// R4: reset is held low for at least four clock edges
// R5: reset drives almost-full and mail flags high, other flags low
// R6: reset clears read and write pointers of both fifos
// R7: each full flag rises on the second edge after reset release
// R8: reset may change level asynchronously to the clock
// R9: offset loads at reset release: 16, 12, 8 or 4
// R10: software resets the device before writing any data
// R11: port-b size and endian latch on one edge, apply on the next
// R12: both port-b size selects high routes port-b access to mailboxes
// R13: swap mode is taken from swap selects at each long-word transfer
// R14: swap codes: 00 none, 01 byte, 10 word, 11 byte-word
// R15: write/read select high writes, low reads, on the next edge
// R16: port-a data drives only with chip select and write/read low
// R17: port-a write to a2b fifo needs select, enable, no mailbox, not full
// R18: port-a read of b2a fifo needs select, enable, no mailbox, not empty
// R19: port-a mailbox select writes a2b mailbox, reads b2a mailbox, frees it
// R20: port-b data drives only with chip select and write/read low
// R21: port-b write to b2a fifo needs select, enable, not full, size not 11
// R22: enable low means no read or write on that edge
// R23: a2b mailbox write drops its flag and blocks writes until port-b read
// R24: reads of an empty fifo are ignored
// R25: writes to a full fifo are ignored
`include "bfifo_defines.svh"
`default_nettype none

// =========================================
// fifo buffer
module bf_fifo #(
  parameter int W = 36,
  parameter int D = 4,
  localparam int AW = $clog2(D)
) (
  // clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_n,
  // filling side
  input  wire logic          i_valid,
  output logic               o_ready,
  input  wire logic [W-1:0]  i_data,
  // draining side
  output logic               o_valid,
  input  wire logic          i_ready,
  output logic [W-1:0]       o_data,
  output logic [AW:0]        o_count
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fs_type;
  localparam logic [AW:0] FULL_C = (AW+1)'(D);
  fs_type s_r, s_nxt;
  logic [W-1:0] mem [D];
  logic push, pop;

  // pointer step with wrap for any depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_ready = s_r.cnt != FULL_C;
  assign o_valid = s_r.cnt != '0;
  assign o_data  = mem[s_r.rp];
  assign o_count = s_r.cnt;
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  // next pointers and count
  always_comb begin
    s_nxt = s_r;
    if (push) s_nxt.wp = step(s_r.wp);
    if (pop) s_nxt.rp = step(s_r.rp);
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // R6: pointers cleared by reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // storage write
  always_ff @(posedge i_ref_clk) begin
    if (push) mem[s_r.wp] <= i_data;
  end
endmodule

// =========================================
// port control top
module bidir_fifo_port_control #(
  parameter int DEPTH = `BF_DEPTH
) (
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  // configuration
  input  wire logic                i_offset_sel_hi,
  input  wire logic                i_offset_sel_lo,
  input  wire logic                i_parity_odd,
  // port a
  input  wire bfifo_pkg::porta_ctl_type i_porta_ctl,
  input  wire bfifo_pkg::data_type i_porta_data,
  output bfifo_pkg::data_type      o_porta_data,
  output logic                     o_porta_data_oe,
  // port b
  input  wire bfifo_pkg::portb_ctl_type i_portb_ctl,
  input  wire bfifo_pkg::data_type i_portb_data,
  output bfifo_pkg::data_type      o_portb_data,
  output logic                     o_portb_data_oe,
  output logic [1:0]               o_portb_bus_size,
  output logic                     o_portb_endian,
  // status
  output bfifo_pkg::flags_type     o_flags
);
  import bfifo_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);
  typedef struct packed {
    logic [1:0] rdy;      // edges since reset release
    logic       off_done;
    logic [4:0] off;
    logic [2:0] szl;      // latched size and endian
    logic [2:0] sza;      // applied size and endian
    flags_type  fl;
    data_type   m1;
    data_type   m2;
    data_type   a_oreg;
    data_type   b_oreg;
    logic       a_oe;
    logic       b_oe;
    data_type   a_dout;
    data_type   b_dout;
  } st_type;
  st_type s_r, s_nxt;
  logic wa, ra, wb, rb, mbb;
  logic a2b_push, a2b_pop, b2a_push, b2a_pop;
  logic a2b_in_rdy, a2b_vld, b2a_in_rdy, b2a_vld;
  data_type a2b_q, b2a_q, b_wdata;
  logic [AW:0] a2b_cnt, b2a_cnt, la, lb;

  // R14: byte order from swap code
  function automatic data_type swap(input data_type d, input logic [1:0] m);
    case (m)
      `BF_SW_BYTE: return {d[8:0], d[17:9], d[26:18], d[35:27]};
      `BF_SW_WORD: return {d[17:0], d[35:18]};
      `BF_SW_BW:   return {d[26:18], d[35:27], d[8:0], d[17:9]};
      default:     return d;
    endcase
  endfunction

  // R2: parity into top bit of each nine-bit byte
  function automatic data_type par(input data_type d, input logic g, input logic odd);
    data_type r;
    r = d;
    for (int i = 0; i < 4; i++) begin
      if (g) r[9*i+8] = (^d[9*i +: 8]) ^ odd;
    end
    return r;
  endfunction
  // R3: generated parity follows odd/even select
  function automatic logic par_ok(input data_type d, input logic odd);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ok = ok && ((^d[9*i +: 9]) == odd);
    end
    return ok;
  endfunction

  // R15: port decodes, write high and read low
  // R22: no read or write decoded with enable low
  assign wa  = !i_porta_ctl.porta_chip_sel_n && i_porta_ctl.porta_wr_rd_sel
               && i_porta_ctl.porta_enable;
  assign ra  = !i_porta_ctl.porta_chip_sel_n && !i_porta_ctl.porta_wr_rd_sel
               && i_porta_ctl.porta_enable;
  assign wb  = !i_portb_ctl.portb_chip_sel_n && i_portb_ctl.portb_wr_rd_sel
               && i_portb_ctl.portb_enable;
  assign rb  = !i_portb_ctl.portb_chip_sel_n && !i_portb_ctl.portb_wr_rd_sel
               && i_portb_ctl.portb_enable;
  // R12: both size selects high picks mailboxes
  assign mbb = &i_portb_ctl.portb_size;

  // R17: a2b write; R25: blocked while full
  assign a2b_push = wa && !i_porta_ctl.porta_mailbox_sel && s_r.fl.porta_full_n && a2b_in_rdy;
  // R21: b2a write; R25: blocked while full
  assign b2a_push = wb && !mbb && s_r.fl.portb_full_n && b2a_in_rdy;
  // R18: b2a read; R24: ignored while empty
  assign b2a_pop  = ra && !i_porta_ctl.porta_mailbox_sel && s_r.fl.porta_empty_n && b2a_vld;
  // R24: a2b read ignored while empty
  assign a2b_pop  = rb && !mbb && s_r.fl.portb_empty_n && a2b_vld;
  // R13: swap taken on each long-word transfer
  assign b_wdata  = swap(i_portb_data, i_portb_ctl.swap_sel);

  bf_fifo #(.W(`BF_DATA_W), .D(DEPTH)) a2b_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_valid   (a2b_push),
    .o_ready   (a2b_in_rdy),
    .i_data    (i_porta_data),
    .o_valid   (a2b_vld),
    .i_ready   (a2b_pop),
    .o_data    (a2b_q),
    .o_count   (a2b_cnt)
  );
  bf_fifo #(.W(`BF_DATA_W), .D(DEPTH)) b2a_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_valid   (b2a_push),
    .o_ready   (b2a_in_rdy),
    .i_data    (b_wdata),
    .o_valid   (b2a_vld),
    .i_ready   (b2a_pop),
    .o_data    (b2a_q),
    .o_count   (b2a_cnt)
  );

  // fill levels after this edge
  assign la = a2b_cnt + (AW+1)'(a2b_push) - (AW+1)'(a2b_pop);
  assign lb = b2a_cnt + (AW+1)'(b2a_push) - (AW+1)'(b2a_pop);

  // next state of the port logic
  always_comb begin
    s_nxt = s_r;
    if (s_r.rdy != `BF_RDY_EDGES) s_nxt.rdy = s_r.rdy + 2'h1;
    // R9: offset from selects at reset release
    if (!s_r.off_done) begin
      s_nxt.off_done = 1'b1;
      case ({i_offset_sel_hi, i_offset_sel_lo})
        2'h3:    s_nxt.off = `BF_OFF_11;
        2'h2:    s_nxt.off = `BF_OFF_10;
        2'h1:    s_nxt.off = `BF_OFF_01;
        default: s_nxt.off = `BF_OFF_00;
      endcase
    end
    // R11: latch on one edge, apply on next
    s_nxt.szl = {i_portb_ctl.portb_size, i_portb_ctl.endian_sel};
    s_nxt.sza = s_r.szl;
    // output registers advance on reads
    if (b2a_pop) s_nxt.a_oreg = b2a_q;
    if (a2b_pop) s_nxt.b_oreg = swap(a2b_q, i_portb_ctl.swap_sel);
    // R19: port-b mailbox reads free a2b mail, port-a mailbox reads free b2a mail
    if (rb && mbb) s_nxt.fl.a2b_mail_flag_n = 1'b1;
    if (ra && i_porta_ctl.porta_mailbox_sel) s_nxt.fl.b2a_mail_flag_n = 1'b1;
    // R23: mail write drops flag, blocked while low
    if (wa && i_porta_ctl.porta_mailbox_sel && s_r.fl.a2b_mail_flag_n) begin
      s_nxt.m1 = i_porta_data;
      s_nxt.fl.a2b_mail_flag_n = 1'b0;
    end
    if (wb && mbb && s_r.fl.b2a_mail_flag_n) begin
      s_nxt.m2 = i_portb_data;
      s_nxt.fl.b2a_mail_flag_n = 1'b0;
    end
    // R7: full flags wait for the second edge
    s_nxt.fl.porta_full_n = (s_nxt.rdy == `BF_RDY_EDGES) && (la != FULL_C);
    s_nxt.fl.portb_full_n = (s_nxt.rdy == `BF_RDY_EDGES) && (lb != FULL_C);
    s_nxt.fl.porta_almost_full_n = la < (FULL_C - (AW+1)'(s_nxt.off));
    s_nxt.fl.portb_almost_full_n = lb < (FULL_C - (AW+1)'(s_nxt.off));
    s_nxt.fl.portb_empty_n = la != '0;
    s_nxt.fl.porta_empty_n = lb != '0;
    s_nxt.fl.portb_almost_empty_n = la > (AW+1)'(s_nxt.off);
    s_nxt.fl.porta_almost_empty_n = lb > (AW+1)'(s_nxt.off);
    // R16: port-a drive enable
    s_nxt.a_oe = !i_porta_ctl.porta_chip_sel_n && !i_porta_ctl.porta_wr_rd_sel;
    // R20: port-b drive enable
    s_nxt.b_oe = !i_portb_ctl.portb_chip_sel_n && !i_portb_ctl.portb_wr_rd_sel;
    s_nxt.a_dout = par(i_porta_ctl.porta_mailbox_sel ? s_nxt.m2 : s_nxt.a_oreg,
                       i_porta_ctl.porta_parity_gen, i_parity_odd);
    // R1: port-b read parity generation
    s_nxt.b_dout = par(mbb ? s_nxt.m1 : s_nxt.b_oreg,
                       i_portb_ctl.portb_parity_gen, i_parity_odd);
  end

  // R5: reset flag levels; R8: asynchronous reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.off <= `BF_OFF_00;
      s_r.fl.porta_almost_full_n <= 1'b1;
      s_r.fl.portb_almost_full_n <= 1'b1;
      s_r.fl.a2b_mail_flag_n <= 1'b1;
      s_r.fl.b2a_mail_flag_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign o_porta_data     = s_r.a_dout;
  assign o_porta_data_oe  = s_r.a_oe;
  assign o_portb_data     = s_r.b_dout;
  assign o_portb_data_oe  = s_r.b_oe;
  assign o_portb_bus_size = s_r.sza[2:1];
  assign o_portb_endian   = s_r.sza[0];
  assign o_flags          = s_r.fl;
  // =========================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence rel_s;
    (s_r.rdy == 2'h0) ##1 (s_r.rdy == 2'h1);
  endsequence
  reset_flags_a: assert property ((s_r.rdy == 2'h0) |-> !o_flags.porta_full_n // R5
    && !o_flags.portb_empty_n && o_flags.porta_almost_full_n && o_flags.a2b_mail_flag_n)
    else $error("flags wrong right after reset");
  full_rise_a: assert property (rel_s |=> o_flags.porta_full_n && o_flags.portb_full_n) // R7
    else $error("full flags not up on second edge");
  porta_oe_a: assert property (o_porta_data_oe == $past(!i_porta_ctl.porta_chip_sel_n // R16
    && !i_porta_ctl.porta_wr_rd_sel))
    else $error("port a drive enable wrong");
  portb_oe_a: assert property (i_portb_ctl.portb_chip_sel_n |=> !o_portb_data_oe) // R20
    else $error("port b drives while deselected");
  no_op_idle_a: assert property (!i_porta_ctl.porta_enable |=> $stable(s_r.m1) // R22
    && a2b_cnt <= $past(a2b_cnt) && b2a_cnt >= $past(b2a_cnt) && $stable(s_r.a_oreg))
    else $error("port a acted while disabled");
  mail_block_a: assert property (!s_r.fl.a2b_mail_flag_n && !(rb && mbb) // R23
    |=> $stable(s_r.m1) && !o_flags.a2b_mail_flag_n)
    else $error("a2b mailbox overwritten");
  empty_ignore_a: assert property (!o_flags.portb_empty_n |=> $stable(s_r.b_oreg) // R24
    && a2b_cnt >= $past(a2b_cnt))
    else $error("read of empty fifo");
  full_ignore_a: assert property (!o_flags.porta_full_n |=> a2b_cnt <= $past(a2b_cnt)) // R25
    else $error("write into full fifo");
  parity_gen_a: assert property (i_portb_ctl.portb_parity_gen // R1
    |=> par_ok(o_portb_data, $past(i_parity_odd)))
    else $error("port b parity wrong");
  size_apply_a: assert property (1'b1 |-> ##2 // R11
    (o_portb_bus_size == $past(i_portb_ctl.portb_size, 2)))
    else $error("bus size not applied two edges later");
endmodule
`default_nettype wire

// [bench/portb_host.sv]
// port-b host model: a processor driving the port-b pins of the device
// assumes the bench calls its tasks in step with i_ref_clk
`default_nettype none
module portb_host (
  // clock
  input  wire logic                     i_ref_clk,
  // port-b pins
  output var  bfifo_pkg::portb_ctl_type o_ctl,
  output var  bfifo_pkg::data_type      o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import bfifo_pkg::*;

  // idle pins at time zero: not selected
  initial begin
    o_ctl = '{portb_chip_sel_n: 1'b1, default: '0};
    o_data = '0;
  end

  // =========================================
  // accesses
  // one access, taken on the second edge, then released
  task automatic access(input logic wr, input logic [1:0] size, sw, input logic pg,
                        input data_type d);
    @(posedge i_ref_clk);
    o_ctl <= '{1'b0, wr, 1'b1, size, 1'b0, sw, pg};
    if (wr) begin
      o_data <= d;
    end
    @(posedge i_ref_clk);
    o_ctl.portb_chip_sel_n <= 1'b1;
    o_ctl.portb_enable <= 1'b0;
    o_data <= ~o_data;  // released bus shows no stale word
  endtask

  // change only the bus-size and endian pins
  task automatic set_size(input logic [1:0] size, input logic be);
    @(posedge i_ref_clk);
    o_ctl.portb_size <= size;
    o_ctl.endian_sel <= be;
  endtask
endmodule
`default_nettype wire

// [bench/test_bidir_fifo_port_control.sv]
// self-checking bench for the port control block
// assumes design, package and portb_host compiled before it
`default_nettype none
module test_bidir_fifo_port_control;
  timeunit 1ns;
  timeprecision 1ns;
  import bfifo_pkg::*;

  // ordinary case: swap, parity, odd select and the word written on port a
  typedef struct packed {
    logic [1:0] sw;
    logic       pg;
    logic       odd;
    data_type   d;
  } row_type;

  localparam row_type rows [6] = '{
    '{2'h0, 1'b0, 1'b0, 36'h1_2345_6789}, '{2'h1, 1'b0, 1'b0, 36'h1_2345_6789},
    '{2'h2, 1'b0, 1'b0, 36'h1_2345_6789}, '{2'h3, 1'b0, 1'b0, 36'h1_2345_6789},
    '{2'h0, 1'b1, 1'b0, 36'h0_f0e1_d2c3}, '{2'h1, 1'b1, 1'b1, 36'h0_f0e1_d2c3}};

  // =========================================
  // signals and instances
  logic          ref_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          off_hi = 1'b0;
  logic          off_lo = 1'b0;
  logic          odd = 1'b0;
  porta_ctl_type porta_ctl = '{porta_chip_sel_n: 1'b1, default: '0};
  data_type      porta_data = '0;
  portb_ctl_type portb_ctl;
  data_type      portb_data, a_out, b_out;
  logic          a_oe, b_oe, be;
  logic [1:0]    bsize;
  flags_type     flags;
  int            err_count = 0;
  int            checks_done = 0;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  bidir_fifo_port_control i_bidir_fifo_port_control (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_offset_sel_hi(off_hi),
    .i_offset_sel_lo(off_lo), .i_parity_odd(odd), .i_porta_ctl(porta_ctl),
    .i_porta_data(porta_data), .o_porta_data(a_out), .o_porta_data_oe(a_oe),
    .i_portb_ctl(portb_ctl), .i_portb_data(portb_data), .o_portb_data(b_out),
    .o_portb_data_oe(b_oe), .o_portb_bus_size(bsize), .o_portb_endian(be),
    .o_flags(flags));

  portb_host i_portb_host (.i_ref_clk(ref_clk), .o_ctl(portb_ctl), .o_data(portb_data));

  // =========================================
  // helpers
  // expected port-b word: byte order, then parity in each byte's top bit
  function automatic data_type swp(input data_type d, input logic [1:0] sw,
                                   input logic pg, od);
    logic [8:0] b [4];
    data_type   r;
    for (int k = 0; k < 4; k++) b[k] = d[9*k +: 9];
    case (sw)
      2'h1: r = {b[0], b[1], b[2], b[3]};
      2'h2: r = {b[1], b[0], b[3], b[2]};
      2'h3: r = {b[2], b[3], b[0], b[1]};
      default: r = d;
    endcase
    if (pg) for (int k = 0; k < 4; k++) r[9*k+8] = ^r[9*k +: 8] ^ od;
    return r;
  endfunction

  // distinct word per fill index
  function automatic data_type w(input int i);
    return {i[8:0], ~i[8:0], i[8:0], 9'h0a5};
  endfunction

  task automatic chk(input string n, input data_type e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkb(input string n, input logic e, g);
    chk(n, data_type'(e), data_type'(g));
  endtask

  // port-a access, taken on the second edge, then released
  task automatic a_acc(input logic wr, mb, en, pg, input data_type d);
    @(posedge ref_clk);
    porta_ctl <= '{1'b0, wr, en, mb, pg};
    porta_data <= wr ? d : porta_data;
    @(posedge ref_clk);
    porta_ctl <= '{porta_chip_sel_n: 1'b1, default: '0};
    porta_data <= ~porta_data;
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // reset asserted off the edge, held, released with an offset code
  task automatic do_reset(input logic [1:0] code);
    @(negedge ref_clk);
    rst_n <= 1'b0;
    #1;
    chk("reset flags", 36'h047, data_type'(flags));
    @(posedge ref_clk);
    {off_hi, off_lo} <= code;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("full held", 36'h0, data_type'({flags.porta_full_n, flags.portb_full_n}));
    @(negedge ref_clk);
    chk("full rise", 36'h3, data_type'({flags.porta_full_n, flags.portb_full_n}));
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog: the run needs under 3000 cycles
  initial begin
    repeat (10000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end

  // =========================================
  // main sequence
  initial begin
    // every offset code; the last fills the a2b fifo to the top
    for (int c = 0; c < 4; c++) begin
      int x, n;
      x = 4 * (c + 1);
      n = (c == 3) ? 64 : x + 1;
      do_reset(2'(c));
      for (int i = 0; i < n; i++) begin
        a_acc(1'b1, 1'b0, 1'b1, 1'b0, w(i));
        settle();
        chkb("almost empty b", i + 1 > x, flags.portb_almost_empty_n);
        chkb("almost full a", i + 1 < 64 - x, flags.porta_almost_full_n);
        chkb("full a", i + 1 < 64, flags.porta_full_n);
      end
    end
    // word offered at full is dropped; drain shows order from a cleared fifo
    a_acc(1'b1, 1'b0, 1'b1, 1'b0, 36'h0_dead_beef);
    for (int i = 0; i < 64; i++) begin
      i_portb_host.access(1'b0, 2'h0, 2'h0, 1'b0, '0);
      @(negedge ref_clk);
      chk("b drain", w(i), b_out);
      settle();
    end
    chkb("empty b", 1'b0, flags.portb_empty_n);
    i_portb_host.access(1'b0, 2'h0, 2'h0, 1'b0, '0);
    @(negedge ref_clk);
    chk("empty read", w(63), b_out);
    // ordinary cases: swap modes and parity on port-b reads
    foreach (rows[k]) begin
      row_type r;
      r = rows[k];
      @(posedge ref_clk);
      odd <= r.odd;
      a_acc(1'b1, 1'b0, 1'b1, 1'b0, r.d);
      settle();
      i_portb_host.access(1'b0, 2'h0, r.sw, r.pg, '0);
      @(negedge ref_clk);
      chk("b swap parity", swp(r.d, r.sw, r.pg, r.odd), b_out);
      chkb("b drive", 1'b1, b_oe);
      settle();
    end
    chkb("b released", 1'b0, b_oe);
    // port-b write with byte swap, read back on port a
    i_portb_host.access(1'b1, 2'h0, 2'h1, 1'b0, 36'h1_2345_6789);
    settle();
    a_acc(1'b0, 1'b0, 1'b1, 1'b0, '0);
    @(negedge ref_clk);
    chk("a read", swp(36'h1_2345_6789, 2'h1, 1'b0, 1'b0), a_out);
    chkb("a drive", 1'b1, a_oe);
    settle();
    chkb("a released", 1'b0, a_oe);
    chkb("empty a", 1'b0, flags.porta_empty_n);
    // enable low: the write is not taken
    a_acc(1'b1, 1'b0, 1'b0, 1'b0, 36'h0_0000_0001);
    settle();
    chkb("no write", 1'b0, flags.portb_empty_n);
    // a2b mailbox: second write blocked until port b reads it
    a_acc(1'b1, 1'b1, 1'b1, 1'b0, 36'h0_aaaa_0001);
    settle();
    chkb("a2b mail flag", 1'b0, flags.a2b_mail_flag_n);
    a_acc(1'b1, 1'b1, 1'b1, 1'b0, 36'h0_aaaa_0002);
    i_portb_host.access(1'b0, 2'h3, 2'h0, 1'b0, '0);
    @(negedge ref_clk);
    chk("b mailbox", 36'h0_aaaa_0001, b_out);
    settle();
    chkb("a2b mail free", 1'b1, flags.a2b_mail_flag_n);
    // b2a mailbox written on port b, read on port a
    i_portb_host.access(1'b1, 2'h3, 2'h0, 1'b0, 36'h0_bbbb_0003);
    settle();
    chkb("b2a mail flag", 1'b0, flags.b2a_mail_flag_n);
    a_acc(1'b0, 1'b1, 1'b1, 1'b0, '0);
    @(negedge ref_clk);
    chk("a mailbox", 36'h0_bbbb_0003, a_out);
    settle();
    chkb("b2a mail free", 1'b1, flags.b2a_mail_flag_n);
    // bus size and endian follow the pins one edge after capture
    i_portb_host.set_size(2'h1, 1'b1);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("size early", 36'h3, data_type'(bsize));
    @(negedge ref_clk);
    chk("size late", 36'h1, data_type'(bsize));
    chkb("endian", 1'b1, be);
    wrap_up();
  end
endmodule
`default_nettype wire
